// *** hdl/pattern_group_update.sv ***
// Purpose: next value of one 4-bit pattern output group
// Assumes: trigger strobes are one-cycle pulses on clk_sys
// Notes: purely combinational, the caller holds the output bits
`timescale 1ns/1ps
module pattern_group_update #(
    parameter int WIDTH = 4
) (
    // triggers of the selected channel
    input wire logic trig_a,
    input wire logic trig_b,
    // group mode: 1 selects non-overlapping output
    input wire logic nonoverlap,
    // data
    input wire logic [WIDTH-1:0] staged,
    input wire logic [WIDTH-1:0] enable,
    input wire logic [WIDTH-1:0] current,
    // result
    output logic [WIDTH-1:0] next_bits
);

    always_comb begin
        next_bits = current;
        if (trig_a) begin
            // copy every enabled staged bit
            next_bits = (enable & staged) | (~enable & current);
        end else if (trig_b && nonoverlap) begin
            // only enabled zeros move ahead
            next_bits = current & ~(enable & ~staged);
        end
    end

endmodule

// *** hdl/pin_input_sync.sv ***
// Purpose: bring an asynchronous level pin into the system clock domain
// Assumes: the pin may change at any time relative to clk_sys
// Notes: the output follows once the second and third stages agree
`timescale 1ns/1ps
module pin_input_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // pin side
    input wire logic pin_in,
    // synchronised level
    output logic level_out
);

    logic meta_reg;
    logic stage2_reg;
    logic stage3_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= RESET_LEVEL;
            stage2_reg <= RESET_LEVEL;
            stage3_reg <= RESET_LEVEL;
        end else begin
            meta_reg <= pin_in;
            stage2_reg <= meta_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // only a level seen on two stages in a row is taken
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            level_out <= RESET_LEVEL;
        end else if (stage2_reg == stage3_reg) begin
            level_out <= stage3_reg;
        end
    end

endmodule

// *** hdl/pulse_group_trigger_mode_select.sv ***
// Purpose: trigger and output mode selection for four 4-bit pattern groups
// Assumes: compare match strobes come from timer logic on clk_sys
// Notes: hardware standby pin reloads all registers; software standby does not
//
// Behaviour
// (RULE_01) trigger select is 8-bit RW, resets 0xFF
// (RULE_02) software standby keeps both registers unchanged
// (RULE_03) bits 7:6 pick group 3 channel
// (RULE_04) bits 5:4 pick group 2 channel
// (RULE_05) bits 3:2 pick group 1 channel
// (RULE_06) bits 1:0 pick group 0 channel
// (RULE_07) group g drives outputs 4g+3 to 4g
// (RULE_08) mode register resets to 0xF0
// (RULE_09) mode bits 7:4 read one, unwritable
// (RULE_10) mode bit zero: update at match A
// (RULE_11) mode bit one: update at A and B
// (RULE_12) software sets period in B, margin in A
// (RULE_13) non-overlap: A copies all, B zeros only
// (RULE_14) only enabled bits copy staged value on trigger
`timescale 1ns/1ps
module pulse_group_trigger_mode_select #(
    parameter int GROUPS = pulse_pattern_pkg::NUM_GROUPS,
    parameter int CHANNELS = pulse_pattern_pkg::NUM_CHANNELS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer unit compare match strobes, one per channel
    input wire logic [CHANNELS-1:0] cmp_match_a,
    input wire logic [CHANNELS-1:0] cmp_match_b,
    // hardware standby pin, active high
    input wire logic hw_standby_pin,
    // pattern outputs
    output logic [15:0] pattern_output_pin
);

    localparam int GW = pulse_pattern_pkg::GROUP_W;
    localparam int SW = pulse_pattern_pkg::SEL_FIELD_W;

    logic [7:0] group_trigger_select_reg;
    logic [7:0] group_output_mode_reg;
    logic [15:0] staged_next_value_reg;
    logic [15:0] bit_enable_reg;
    logic [15:0] port_output_bits_reg;
    logic [15:0] port_output_bits_next;
    logic [15:0] trig_port_bits;
    logic [GROUPS-1:0] grp_trig_a;
    logic [GROUPS-1:0] grp_trig_b;
    logic hw_standby;
    logic wr_done;
    logic rd_take;
    pulse_pattern_pkg::bus_state_t bus_state_reg;
    pulse_pattern_pkg::bus_state_t bus_state_next;

    // register index from byte address, invalid gives 3'h7
    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        logic [2:0] idx;
        idx = 3'h7;
        unique case (addr)
            pulse_pattern_pkg::OFF_TRIG_SEL: idx = 3'h0;
            pulse_pattern_pkg::OFF_OUT_MODE: idx = 3'h1;
            pulse_pattern_pkg::OFF_STAGED: idx = 3'h2;
            pulse_pattern_pkg::OFF_BIT_EN: idx = 3'h3;
            pulse_pattern_pkg::OFF_PORT_BITS: idx = 3'h4;
            default: idx = 3'h7;
        endcase
        return idx;
    endfunction

    // channel code of one group
    function automatic logic [1:0] chan_of(input logic [7:0] sel, input int grp);
        return sel[grp*SW +: SW];
    endfunction

    pin_input_sync #(
        .RESET_LEVEL(1'b0)
    ) u_standby_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(hw_standby_pin),
        .level_out(hw_standby)
    );

    // ---- bus answer: one wait state, then pready for one cycle
    always_comb begin
        bus_state_next = bus_state_reg;
        unique case (bus_state_reg)
            pulse_pattern_pkg::BUS_IDLE: begin
                if (psel && penable) begin
                    bus_state_next = pulse_pattern_pkg::BUS_ANSWER;
                end
            end
            pulse_pattern_pkg::BUS_ANSWER: bus_state_next = pulse_pattern_pkg::BUS_DONE;
            pulse_pattern_pkg::BUS_DONE: bus_state_next = pulse_pattern_pkg::BUS_IDLE;
            default: bus_state_next = pulse_pattern_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_reg <= pulse_pattern_pkg::BUS_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    assign rd_take = (bus_state_reg == pulse_pattern_pkg::BUS_IDLE) && psel && penable;
    assign wr_done = (bus_state_reg == pulse_pattern_pkg::BUS_ANSWER) && psel && penable && pwrite
        && (reg_index(paddr) != 3'h7);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= rd_take;
            pslverr <= rd_take && (reg_index(paddr) == 3'h7);
            if (rd_take) begin
                unique case (reg_index(paddr))
                    3'h0: prdata <= {24'h00_0000, group_trigger_select_reg};
                    3'h1: prdata <= {24'h00_0000, group_output_mode_reg};
                    3'h2: prdata <= {16'h0000, staged_next_value_reg};
                    3'h3: prdata <= {16'h0000, bit_enable_reg};
                    3'h4: prdata <= {16'h0000, port_output_bits_reg};
                    default: prdata <= 32'h0000_0000;
                endcase
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ---- trigger select register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            group_trigger_select_reg <= pulse_pattern_pkg::TRIG_SEL_RESET; // RULE_01
        end else if (hw_standby) begin
            group_trigger_select_reg <= pulse_pattern_pkg::TRIG_SEL_RESET; // RULE_01
        end else if (wr_done && reg_index(paddr) == 3'h0) begin
            group_trigger_select_reg <= pwdata[7:0]; // RULE_01 RULE_02
        end
    end

    // ---- mode register, upper nibble fixed at one
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            group_output_mode_reg <= pulse_pattern_pkg::OUT_MODE_RESET; // RULE_08
        end else if (hw_standby) begin
            group_output_mode_reg <= pulse_pattern_pkg::OUT_MODE_RESET; // RULE_08
        end else if (wr_done && reg_index(paddr) == 3'h1) begin
            group_output_mode_reg <= pwdata[7:0] | pulse_pattern_pkg::MODE_RSVD_MASK; // RULE_09 RULE_02
        end
    end

    // ---- staged values and per-bit enables
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            staged_next_value_reg <= pulse_pattern_pkg::STAGED_RESET;
            bit_enable_reg <= pulse_pattern_pkg::BIT_EN_RESET;
        end else if (hw_standby) begin
            staged_next_value_reg <= pulse_pattern_pkg::STAGED_RESET;
            bit_enable_reg <= pulse_pattern_pkg::BIT_EN_RESET;
        end else if (wr_done) begin
            if (reg_index(paddr) == 3'h2) begin
                staged_next_value_reg <= pwdata[15:0];
            end
            if (reg_index(paddr) == 3'h3) begin
                bit_enable_reg <= pwdata[15:0];
            end
        end
    end

    // ---- per group trigger routing and update
    genvar g;
    generate
        for (g = 0; g < GROUPS; g++) begin : gen_group
            // selected channel strobes for this group
            assign grp_trig_a[g] = cmp_match_a[chan_of(group_trigger_select_reg, g)]; // RULE_03 RULE_04 RULE_05 RULE_06
            assign grp_trig_b[g] = cmp_match_b[chan_of(group_trigger_select_reg, g)]; // RULE_03 RULE_04 RULE_05 RULE_06

            pattern_group_update #(
                .WIDTH(GW)
            ) u_update (
                .trig_a(grp_trig_a[g]), // RULE_10
                .trig_b(grp_trig_b[g]), // RULE_11
                .nonoverlap(group_output_mode_reg[pulse_pattern_pkg::MODE_NOV_LSB + g]), // RULE_10 RULE_11
                .staged(staged_next_value_reg[g*GW +: GW]), // RULE_07
                .enable(bit_enable_reg[g*GW +: GW]), // RULE_14
                .current(port_output_bits_reg[g*GW +: GW]), // RULE_07
                .next_bits(trig_port_bits[g*GW +: GW]) // RULE_13
            );
        end
    endgenerate

    // software may write only bits not under trigger control
    always_comb begin
        port_output_bits_next = trig_port_bits;
        if (wr_done && reg_index(paddr) == 3'h4) begin
            port_output_bits_next = (trig_port_bits & bit_enable_reg) | (pwdata[15:0] & ~bit_enable_reg); // RULE_14
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            port_output_bits_reg <= pulse_pattern_pkg::PORT_BITS_RESET;
        end else if (hw_standby) begin
            port_output_bits_reg <= pulse_pattern_pkg::PORT_BITS_RESET;
        end else begin
            port_output_bits_reg <= port_output_bits_next; // RULE_14
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pattern_output_pin <= pulse_pattern_pkg::PORT_BITS_RESET;
        end else if (hw_standby) begin
            pattern_output_pin <= pulse_pattern_pkg::PORT_BITS_RESET;
        end else begin
            pattern_output_pin <= port_output_bits_next; // RULE_07
        end
    end

    // ---- checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_standby;
        hw_standby;
    endsequence

    sequence s_trig_write;
        wr_done && reg_index(paddr) == 3'h0;
    endsequence

    sequence s_mode_write;
        wr_done && reg_index(paddr) == 3'h1;
    endsequence

    trig_standby_a: assert property (s_standby |=> group_trigger_select_reg == 8'hFF) // RULE_01
        else $error("trigger select not reloaded by standby");

    trig_write_a: assert property (s_trig_write ##0 !hw_standby // RULE_01
        |=> group_trigger_select_reg == $past(pwdata[7:0]))
        else $error("trigger select write lost");

    regs_hold_a: assert property (!hw_standby && !wr_done |=> $stable(group_trigger_select_reg) // RULE_02
        && $stable(group_output_mode_reg))
        else $error("control registers changed without write or standby");

    mode_standby_a: assert property (s_standby |=> group_output_mode_reg == 8'hF0) // RULE_08
        else $error("mode register not reloaded by standby");

    mode_rsvd_a: assert property (group_output_mode_reg[7:4] == 4'hF) // RULE_09
        else $error("reserved mode bits not one");

    mode_write_a: assert property (s_mode_write ##0 !hw_standby // RULE_10
        |=> group_output_mode_reg[3:0] == $past(pwdata[3:0]))
        else $error("mode bits write lost");

    grp3_route_a: assert property (grp_trig_a[3] == cmp_match_a[group_trigger_select_reg[7:6]]) // RULE_03
        else $error("group 3 trigger routed wrong");

    grp2_route_a: assert property (grp_trig_a[2] == cmp_match_a[group_trigger_select_reg[5:4]]) // RULE_04
        else $error("group 2 trigger routed wrong");

    grp1_route_a: assert property (grp_trig_b[1] == cmp_match_b[group_trigger_select_reg[3:2]]) // RULE_05
        else $error("group 1 trigger routed wrong");

    grp0_route_a: assert property (grp_trig_a[0] == cmp_match_a[group_trigger_select_reg[1:0]]) // RULE_06
        else $error("group 0 trigger routed wrong");

    grp3_copy_a: assert property (grp_trig_a[3] && !hw_standby && !wr_done // RULE_07
        |=> pattern_output_pin[15:12] == ($past(staged_next_value_reg[15:12]) & $past(bit_enable_reg[15:12])
        | $past(port_output_bits_reg[15:12]) & ~$past(bit_enable_reg[15:12])))
        else $error("group 3 outputs not updated from staged bits");

    normal_b_a: assert property (!grp_trig_a[0] && grp_trig_b[0] && !group_output_mode_reg[0] // RULE_10
        && !hw_standby && !wr_done |=> $stable(port_output_bits_reg[3:0]))
        else $error("normal group changed at match B");

    nov_b_zero_a: assert property (!grp_trig_a[1] && grp_trig_b[1] && group_output_mode_reg[1] // RULE_13
        && !hw_standby && !wr_done |=> port_output_bits_reg[7:4] == ($past(port_output_bits_reg[7:4])
        & ~($past(bit_enable_reg[7:4]) & ~$past(staged_next_value_reg[7:4]))))
        else $error("match B moved a one or missed a zero");

    nov_a_all_a: assert property (grp_trig_a[2] && group_output_mode_reg[2] && !hw_standby && !wr_done // RULE_11
        |=> (port_output_bits_reg[11:8] & $past(bit_enable_reg[11:8]))
        == ($past(staged_next_value_reg[11:8]) & $past(bit_enable_reg[11:8])))
        else $error("match A did not copy all enabled bits");

    disabled_hold_a: assert property (!hw_standby && !wr_done // RULE_14
        |=> (port_output_bits_reg & ~$past(bit_enable_reg)) == ($past(port_output_bits_reg) & ~$past(bit_enable_reg)))
        else $error("disabled bit changed on trigger");

    pins_standby_a: assert property (s_standby |=> pattern_output_pin == 16'h0000) // RULE_07
        else $error("pattern pins not cleared by standby");

    bus_answer_a: assert property (rd_take |=> pready ##1 !pready)
        else $error("bus answer not a single cycle");

    grp3_b_route_a: assert property (grp_trig_b[3] == cmp_match_b[group_trigger_select_reg[7:6]]) // RULE_03
        else $error("group 3 match B routed wrong");

    grp2_b_route_a: assert property (grp_trig_b[2] == cmp_match_b[group_trigger_select_reg[5:4]]) // RULE_04
        else $error("group 2 match B routed wrong");

    grp1_a_route_a: assert property (grp_trig_a[1] == cmp_match_a[group_trigger_select_reg[3:2]]) // RULE_05
        else $error("group 1 match A routed wrong");

    grp0_b_route_a: assert property (grp_trig_b[0] == cmp_match_b[group_trigger_select_reg[1:0]]) // RULE_06
        else $error("group 0 match B routed wrong");

    trig_read_a: assert property (rd_take && reg_index(paddr) == 3'h0 // RULE_01
        |=> prdata == {24'h00_0000, $past(group_trigger_select_reg)})
        else $error("trigger select read wrong");

    mode_read_a: assert property (rd_take && reg_index(paddr) == 3'h1 |=> prdata[7:4] == 4'hF) // RULE_09
        else $error("reserved mode bits not read as one");

    bad_addr_a: assert property (rd_take && reg_index(paddr) == 3'h7
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    grp3_normal_b_a: assert property (!grp_trig_a[3] && grp_trig_b[3] && !group_output_mode_reg[3] // RULE_10
        && !hw_standby && !wr_done |=> $stable(port_output_bits_reg[15:12]))
        else $error("normal group 3 changed at match B");

    grp2_nov_b_a: assert property (!grp_trig_a[2] && grp_trig_b[2] && group_output_mode_reg[2] // RULE_13
        && !hw_standby && !wr_done |=> port_output_bits_reg[11:8] == ($past(port_output_bits_reg[11:8])
        & ~($past(bit_enable_reg[11:8]) & ~$past(staged_next_value_reg[11:8]))))
        else $error("group 2 match B moved a one");

endmodule

// *** hdl/pulse_pattern_pkg.sv ***
// Purpose: shared constants for the pulse pattern group trigger and mode block
// Assumes: APB register access, 32-bit data, one aligned word per register
// Notes: offsets are byte addresses on the register bus
package pulse_pattern_pkg;

    // register map
    localparam logic [7:0] OFF_TRIG_SEL = 8'h00;
    localparam logic [7:0] OFF_OUT_MODE = 8'h04;
    localparam logic [7:0] OFF_STAGED = 8'h08;
    localparam logic [7:0] OFF_BIT_EN = 8'h0C;
    localparam logic [7:0] OFF_PORT_BITS = 8'h10;

    // reset values
    localparam logic [7:0] TRIG_SEL_RESET = 8'hFF;
    localparam logic [7:0] OUT_MODE_RESET = 8'hF0;
    localparam logic [15:0] STAGED_RESET = 16'h0000;
    localparam logic [15:0] BIT_EN_RESET = 16'h0000;
    localparam logic [15:0] PORT_BITS_RESET = 16'h0000;

    // field layout
    localparam logic [7:0] MODE_RSVD_MASK = 8'hF0;
    localparam int MODE_NOV_LSB = 0;
    localparam int SEL_FIELD_W = 2;
    localparam int GROUP_W = 4;
    localparam int NUM_GROUPS = 4;
    localparam int NUM_CHANNELS = 4;
    localparam int REG_W = 8;
    localparam int PAT_W = 16;

    // pin input synchroniser depth
    localparam int SYNC_STAGES = 3;

    // bus answer sequence, gray coded
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ANSWER = 2'b01,
        BUS_DONE = 2'b11
    } bus_state_t;

endpackage

// *** test/pulse_group_trigger_mode_select_bench.sv ***
// Purpose: self-checking bench for group trigger and mode selection
// Assumes: apb answers after one wait state, strobes come from the timer model
// Notes: expected pins come from a small reference of the copy rules
`timescale 1ns/1ps
module pulse_group_trigger_mode_select_bench;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, hw_standby_pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] cmp_match_a, cmp_match_b;
    logic [15:0] pattern_output_pin, stg_v, en_v, exp_pins;
    logic [7:0] tsel_v;
    logic [3:0] mode_v;
    logic err;
    int bad_count, compares;

    pulse_group_trigger_mode_select dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_match_a(cmp_match_a), .cmp_match_b(cmp_match_b), .hw_standby_pin(hw_standby_pin),
        .pattern_output_pin(pattern_output_pin));
    timer_strobe_model model (.clk_sys(clk_sys), .cmp_match_a(cmp_match_a), .cmp_match_b(cmp_match_b));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic fail_msg(input string what);
        bad_count++;
        $display("[FAIL] %0t %s", $time, what);
    endtask
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) fail_msg($sformatf("%s read %h expected %h", what, got, exp));
    endtask
    task automatic check_err(input logic got, input logic exp);
        compares++;
        if (got !== exp) fail_msg($sformatf("error flag %b expected %b", got, exp));
    endtask
    task automatic check_pins(input logic [15:0] exp);
        compares++;
        if (pattern_output_pin !== exp) fail_msg($sformatf("pins %h expected %h", pattern_output_pin, exp));
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_msg("no bus answer");
            finish_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
        check_err(err, 1'b0);
    endtask
    task automatic reg_read_check(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h00000000, rd, err);
        check_reg(rd, exp, what);
    endtask

    // reference: apply one strobe of channel ch to the expected pins
    task automatic model_event(input int ch, input logic a, input logic b);
        logic [3:0] s, e, c;
        for (int g = 0; g < 4; g++) begin
            s = stg_v[4*g +: 4];
            e = en_v[4*g +: 4];
            c = exp_pins[4*g +: 4];
            if (tsel_v[2*g +: 2] == 2'(ch)) begin
                if (a) c = (e & s) | (~e & c);
                else if (b && mode_v[g]) c = c & ~(e & ~s);
            end
            exp_pins[4*g +: 4] = c;
        end
    endtask
    task automatic fire(input int ch, input logic a, input logic b);
        model.pulse(ch, a, b);
        model_event(ch, a, b);
        #1;
        check_pins(exp_pins);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        hw_standby_pin = 1'b0;
        bad_count = 0;
        compares = 0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        reg_read_check(pulse_pattern_pkg::OFF_TRIG_SEL, 32'h000000FF, "trig reset");
        reg_read_check(pulse_pattern_pkg::OFF_OUT_MODE, 32'h000000F0, "mode reset");
        check_pins(16'h0000);
        $display("test reset values done");

        reg_write(pulse_pattern_pkg::OFF_TRIG_SEL, 32'hFFFFFF5A);
        reg_read_check(pulse_pattern_pkg::OFF_TRIG_SEL, 32'h0000005A, "trig rw");
        reg_write(pulse_pattern_pkg::OFF_OUT_MODE, 32'h0000000A);
        reg_read_check(pulse_pattern_pkg::OFF_OUT_MODE, 32'h000000FA, "mode ones");
        reg_write(pulse_pattern_pkg::OFF_OUT_MODE, 32'h00000000);
        reg_read_check(pulse_pattern_pkg::OFF_OUT_MODE, 32'h000000F0, "mode reserved");
        apb(1'b1, 8'h24, 32'h00000000, rd, err);
        check_err(err, 1'b1);
        apb(1'b0, 8'h20, 32'h00000000, rd, err);
        check_err(err, 1'b1);
        check_reg(rd, 32'h00000000, "unmapped");
        reg_read_check(pulse_pattern_pkg::OFF_TRIG_SEL, 32'h0000005A, "trig kept");
        $display("test register access done");

        mode_v = 4'h0;
        en_v = 16'hF7EE;
        exp_pins = ~en_v;
        reg_write(pulse_pattern_pkg::OFF_BIT_EN, {16'h0000, en_v});
        reg_write(pulse_pattern_pkg::OFF_PORT_BITS, 32'h0000FFFF);
        #1;
        check_pins(exp_pins);
        for (int r = 0; r < 4; r++) begin
            tsel_v = {2'(3 + r), 2'(2 + r), 2'(1 + r), 2'(r)};
            reg_write(pulse_pattern_pkg::OFF_TRIG_SEL, {24'h000000, tsel_v});
            for (int ch = 0; ch < 4; ch++) begin
                stg_v = {4{4'(r * 4 + ch)}} ^ 16'h5A3C;
                reg_write(pulse_pattern_pkg::OFF_STAGED, {16'h0000, stg_v});
                fire(ch, 1'b0, 1'b1);
                fire(ch, 1'b1, 1'b0);
            end
        end
        $display("test normal triggers done");

        mode_v = 4'h7;
        tsel_v = 8'h00;
        stg_v = 16'h9A5C;
        reg_write(pulse_pattern_pkg::OFF_OUT_MODE, 32'h00000007);
        reg_read_check(pulse_pattern_pkg::OFF_OUT_MODE, 32'h000000F7, "mode nov");
        reg_write(pulse_pattern_pkg::OFF_TRIG_SEL, 32'h00000000);
        reg_write(pulse_pattern_pkg::OFF_STAGED, {16'h0000, stg_v});
        fire(0, 1'b1, 1'b0);
        stg_v = 16'h6A39;
        reg_write(pulse_pattern_pkg::OFF_STAGED, {16'h0000, stg_v});
        fire(0, 1'b0, 1'b1);
        stg_v = 16'hC3F0;
        reg_write(pulse_pattern_pkg::OFF_STAGED, {16'h0000, stg_v});
        model.nov_period(0, 3);
        model_event(0, 1'b0, 1'b1);
        model_event(0, 1'b1, 1'b0);
        #1;
        check_pins(exp_pins);
        fire(0, 1'b1, 1'b1);
        $display("test non-overlap done");

        reg_read_check(pulse_pattern_pkg::OFF_TRIG_SEL, 32'h00000000, "trig held");
        reg_read_check(pulse_pattern_pkg::OFF_OUT_MODE, 32'h000000F7, "mode held");
        @(posedge clk_sys);
        hw_standby_pin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        check_pins(16'h0000);
        reg_read_check(pulse_pattern_pkg::OFF_TRIG_SEL, 32'h000000FF, "trig standby");
        reg_read_check(pulse_pattern_pkg::OFF_OUT_MODE, 32'h000000F0, "mode standby");
        @(posedge clk_sys);
        hw_standby_pin <= 1'b0;
        repeat (8) @(posedge clk_sys);
        tsel_v = 8'hFF;
        mode_v = 4'h0;
        stg_v = 16'h0000;
        en_v = 16'h0000;
        exp_pins = 16'h0000;
        fire(3, 1'b1, 1'b0);
        $display("test standby done");
        finish_test();
    end
endmodule

// *** test/timer_strobe_model.sv ***
// Purpose: timer unit channels issuing compare match strobes
// Assumes: strobes are one-cycle pulses on clk_sys
// Notes: strobes stay low unless the bench commands a pulse
`timescale 1ns/1ps
module timer_strobe_model #(
    parameter int CHANNELS = 4
) (
    // clock
    input wire logic clk_sys,
    // compare match strobes, one per channel
    output logic [CHANNELS-1:0] cmp_match_a,
    output logic [CHANNELS-1:0] cmp_match_b
);
    initial begin
        cmp_match_a = '0;
        cmp_match_b = '0;
    end

    // one-cycle strobe on channel ch, match a and/or b
    task automatic pulse(input int ch, input logic a, input logic b);
        @(posedge clk_sys);
        cmp_match_a[ch] <= a;
        cmp_match_b[ch] <= b;
        @(posedge clk_sys);
        cmp_match_a[ch] <= 1'b0;
        cmp_match_b[ch] <= 1'b0;
    endtask

    // period ends at match b, margin plus two cycles later match a
    task automatic nov_period(input int ch, input int margin);
        pulse(ch, 1'b0, 1'b1);
        repeat (margin) @(posedge clk_sys);
        pulse(ch, 1'b1, 1'b0);
    endtask
endmodule
